/* File: shared/tco_regs.vh */
`ifndef TCO_REGS_VH
`define TCO_REGS_VH
// software register byte addresses
`define TCO_A_CTRL      8'h00
`define TCO_A_STATUS    8'h04
`define TCO_A_BASE      8'h08
`define TCO_A_CMDWORD   8'h0c
`define TCO_A_LINK      8'h10
`define TCO_A_TBDARR    8'h14
`define TCO_A_MODE      8'h18
`define TCO_A_HDROFS    8'h1c
`define TCO_A_BUF0      8'h20
`define TCO_A_BUF0LEN   8'h24
`define TCO_A_SEGCTL    8'h28
`define TCO_A_MTU       8'h2c
`define TCO_A_FRMLEN    8'h30
`define TCO_A_SUM       8'h34
`define TCO_A_PHDR0     8'h40
`define TCO_PHDR_WORDS  6
// control and status bits
`define TCO_CTRL_GO     0
`define TCO_CTRL_FRAG   1
`define TCO_ST_BUSY     0
`define TCO_ST_DONE     1
`define TCO_ST_ECOMBO   2
`define TCO_ST_EFRAG    3
`define TCO_ST_EMTU     4
// command block word offsets
`define TCO_OFS_CMD     8'h00
`define TCO_OFS_LINK    8'h04
`define TCO_OFS_TBDARR  8'h08
`define TCO_OFS_LEN     8'h0c
`define TCO_OFS_ACT     8'h10
`define TCO_OFS_HDROFS  8'h14
`define TCO_OFS_BUF0    8'h18
`define TCO_OFS_BUF0LEN 8'h1c
`define TCO_CB_WORDS    8
// activation bits inside the word at 10h
`define TCO_ACT_IPCSUM  20
`define TCO_ACT_L4CSUM  21
`define TCO_ACT_ISTCP   22
`define TCO_ACT_LSEND   23
`define TCO_ACT_HWPARSE 24
`define TCO_ACT_VLAN    25
`define TCO_ACT_SCHED   28
`define TCO_ACT_MASK    12'h13f
`define TCO_BYTECNT_W   14
`define TCO_VLAN_BYTES  16'h0004
`define TCO_TCP_CSUM_OFS 8'h10
`define TCO_UDP_CSUM_OFS 8'h06
`define TCO_MTU_RESET   16'h05ee
`endif

/* File: rtl/tco_host.v */
`timescale 1ns/1ps
`include "tco_regs.vh"
// Contract
// - with large send off, count subfield holds this block's descriptor total.
// - only supported mode combinations may be set; others are refused.
// - frame length plus inserted tag bytes must stay within the MTU.
// - no offload of any kind is requested for an IP fragment; code tests FRAG from the previous CTRL write, not the GO write.
// - device handles outer IP only; host supplies inner IP header checksums.
// - host writes pseudo-header partial sum into the frame checksum field.
// - partial sum is plain one's complement sum of six words, not complemented.
// - link pointer at 4h, descriptor array pointer at 8h.
// - lower half of word Ch holds 14-bit immediate byte count.
// - word 10h holds 12-bit activation field over 20-bit scheduling value.
// - word 14h holds TCP and IP header offsets over the 16-bit tag.
// - buffer address at 18h; 1Ch holds total payload over 14-bit buffer size.
module tco_host (
    input  wire        i_clock,
    input  wire        i_reset,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_write,
    input  wire        i_read,
    output reg  [31:0] o_rdata,
    output reg         o_mem_write,
    output reg  [31:0] o_mem_addr,
    output reg  [31:0] o_mem_wdata,
    output reg  [3:0]  o_mem_be,
    output reg         o_busy
);
    localparam [3:0] S_IDLE  = 4'b0001;
    localparam [3:0] S_SUM   = 4'b0010;
    localparam [3:0] S_WRITE = 4'b0100;
    localparam [3:0] S_SEED  = 4'b1000;

    reg  [3:0]  state;
    reg  [31:0] base;
    reg  [31:0] cmd_word;
    reg  [31:0] link;
    reg  [31:0] tbd_array;
    reg  [31:0] mode;
    reg  [31:0] hdr_ofs;
    reg  [31:0] buf0;
    reg  [31:0] buf0_len;
    reg  [31:0] seg_ctl;
    reg  [15:0] mtu;
    reg  [15:0] frame_len;
    reg         frag;
    reg  [15:0] sum;
    reg  [2:0]  idx;
    reg         done;
    reg         err_combo;
    reg         err_frag;
    reg         err_mtu;
    reg  [31:0] next_rdata;
    reg  [31:0] next_data;
    reg  [16:0] sum_wide;
    reg  [15:0] pick_word;
    wire [15:0] phdr [0:`TCO_PHDR_WORDS-1];

    wire go       = i_write && (i_addr == `TCO_A_CTRL) && i_wdata[`TCO_CTRL_GO];
    wire l4_csum  = mode[`TCO_ACT_L4CSUM];
    wire is_tcp   = mode[`TCO_ACT_ISTCP];
    wire lsend    = mode[`TCO_ACT_LSEND];
    wire hw_parse = mode[`TCO_ACT_HWPARSE];
    wire vlan_on  = mode[`TCO_ACT_VLAN];
    wire sched_on = mode[`TCO_ACT_SCHED];
    wire any_off  = |(mode[31:20] & `TCO_ACT_MASK);
    // large send is TCP only and needs the TCP checksum
    wire bad_combo = lsend && !(l4_csum && is_tcp);
    wire bad_frag  = frag && any_off;
    wire [16:0] wire_len = {1'b0, frame_len} + (vlan_on ? {1'b0, `TCO_VLAN_BYTES} : 17'h00000);
    wire bad_mtu   = wire_len > {1'b0, mtu};
    // one seed per frame: outer header only, inner ones are software's
    wire [31:0] seed_addr = buf0 + {24'h000000, hdr_ofs[31:24]}
                          + {24'h000000, (is_tcp ? `TCO_TCP_CSUM_OFS : `TCO_UDP_CSUM_OFS)};

    // per-entry pseudo-header word registers
    genvar g;
    generate
        for (g = 0; g < `TCO_PHDR_WORDS; g = g + 1) begin : g_phdr
            localparam [31:0] WORD_ADDR = `TCO_A_PHDR0 + 4 * g;
            reg [15:0] word;
            always @(posedge i_clock or posedge i_reset) begin
                if (i_reset) begin
                    word <= 16'h0000;
                end else if (i_write && state == S_IDLE && (i_addr == WORD_ADDR[7:0])) begin
                    word <= i_wdata[15:0];
                end
            end
            assign phdr[g] = word;
        end
    endgenerate

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            base      <= 32'h00000000;
            cmd_word  <= 32'h00000000;
            link      <= 32'h00000000;
            tbd_array <= 32'h00000000;
            mode      <= 32'h00000000;
            hdr_ofs   <= 32'h00000000;
            buf0      <= 32'h00000000;
            buf0_len  <= 32'h00000000;
            seg_ctl   <= 32'h00000000;
            mtu       <= `TCO_MTU_RESET;
            frame_len <= 16'h0000;
            frag      <= 1'b0;
        end else if (i_write && state == S_IDLE) begin
            case (i_addr)
                `TCO_A_CTRL:    frag      <= i_wdata[`TCO_CTRL_FRAG];
                `TCO_A_BASE:    base      <= i_wdata;
                `TCO_A_CMDWORD: cmd_word  <= i_wdata;
                `TCO_A_LINK:    link      <= i_wdata;
                `TCO_A_TBDARR:  tbd_array <= i_wdata;
                `TCO_A_MODE:    mode      <= i_wdata;
                `TCO_A_HDROFS:  hdr_ofs   <= i_wdata;
                `TCO_A_BUF0:    buf0      <= i_wdata;
                `TCO_A_BUF0LEN: buf0_len  <= i_wdata;
                `TCO_A_SEGCTL:  seg_ctl   <= i_wdata;
                `TCO_A_MTU:     mtu       <= i_wdata[15:0];
                `TCO_A_FRMLEN:  frame_len <= i_wdata[15:0];
                default: ;
            endcase
        end
    end

    // command block word contents
    always @* begin
        next_data = 32'h00000000;
        case (idx)
            3'd0: next_data = cmd_word;
            3'd1: next_data = link;
            3'd2: next_data = tbd_array;
            3'd3: begin
                // large send off: count in upper half, byte count in low 14 bits
                next_data[31:16] = seg_ctl[31:16];
                next_data[`TCO_BYTECNT_W-1:0] = seg_ctl[`TCO_BYTECNT_W-1:0];
            end
            3'd4: begin
                next_data[31:20] = mode[31:20] & `TCO_ACT_MASK;
                next_data[19:0]  = sched_on ? mode[19:0] : 20'h00000;
            end
            3'd5: begin
                next_data[31:16] = hw_parse ? 16'h0000 : hdr_ofs[31:16];
                next_data[15:0]  = vlan_on ? hdr_ofs[15:0] : 16'h0000;
            end
            3'd6: next_data = buf0;
            3'd7: begin
                next_data[31:16] = buf0_len[31:16];
                next_data[`TCO_BYTECNT_W-1:0] = buf0_len[`TCO_BYTECNT_W-1:0];
            end
            default: next_data = 32'h00000000;
        endcase
        if (idx == 3'd3 && !lsend && seg_ctl[31:16] == 16'h0000) begin
            next_data[31:16] = 16'h0000;
        end
    end

    // only six pseudo words; other indices add nothing
    always @* begin
        pick_word = 16'h0000;
        case (idx)
            3'd0: pick_word = phdr[0];
            3'd1: pick_word = phdr[1];
            3'd2: pick_word = phdr[2];
            3'd3: pick_word = phdr[3];
            3'd4: pick_word = phdr[4];
            3'd5: pick_word = phdr[5];
            default: pick_word = 16'h0000;
        endcase
        sum_wide = {1'b0, sum} + {1'b0, pick_word};
    end

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state       <= S_IDLE;
            idx         <= 3'd0;
            sum         <= 16'h0000;
            done        <= 1'b0;
            err_combo   <= 1'b0;
            err_frag    <= 1'b0;
            err_mtu     <= 1'b0;
            o_busy      <= 1'b0;
            o_mem_write <= 1'b0;
            o_mem_addr  <= 32'h00000000;
            o_mem_wdata <= 32'h00000000;
            o_mem_be    <= 4'h0;
        end else begin
            o_mem_write <= 1'b0;
            o_mem_be    <= 4'h0;
            case (state)
                S_IDLE: begin
                    // busy falls the cycle after the last memory write
                    o_busy <= 1'b0;
                    if (go) begin
                        done      <= 1'b0;
                        err_combo <= bad_combo;
                        err_frag  <= bad_frag;
                        err_mtu   <= bad_mtu;
                        idx       <= 3'd0;
                        sum       <= 16'h0000;
                        if (!(bad_combo || bad_frag || bad_mtu)) begin
                            state  <= S_SUM;
                            o_busy <= 1'b1;
                        end
                    end
                end
                S_SUM: begin
                    sum <= sum_wide[15:0] + {15'h0000, sum_wide[16]};
                    if (idx == `TCO_PHDR_WORDS - 1) begin
                        idx   <= 3'd0;
                        state <= S_WRITE;
                    end else begin
                        idx <= idx + 3'd1;
                    end
                end
                S_WRITE: begin
                    o_mem_write <= 1'b1;
                    o_mem_be    <= 4'hf;
                    o_mem_addr  <= base + {27'h0000000, idx, 2'b00};
                    o_mem_wdata <= next_data;
                    if (idx == `TCO_CB_WORDS - 1) begin
                        state <= l4_csum ? S_SEED : S_IDLE;
                        done  <= !l4_csum;
                    end else begin
                        idx <= idx + 3'd1;
                    end
                end
                S_SEED: begin
                    // seed is not complemented; device finishes the sum
                    o_mem_write <= 1'b1;
                    o_mem_addr  <= {seed_addr[31:2], 2'b00};
                    o_mem_be    <= seed_addr[1] ? 4'hc : 4'h3;
                    o_mem_wdata <= {sum[7:0], sum[15:8], sum[7:0], sum[15:8]};
                    done        <= 1'b1;
                    state       <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    always @* begin
        next_rdata = 32'h00000000;
        case (i_addr)
            `TCO_A_STATUS:  next_rdata = {27'h0000000, err_mtu, err_frag, err_combo, done, o_busy};
            `TCO_A_BASE:    next_rdata = base;
            `TCO_A_CMDWORD: next_rdata = cmd_word;
            `TCO_A_LINK:    next_rdata = link;
            `TCO_A_TBDARR:  next_rdata = tbd_array;
            `TCO_A_MODE:    next_rdata = mode;
            `TCO_A_HDROFS:  next_rdata = hdr_ofs;
            `TCO_A_BUF0:    next_rdata = buf0;
            `TCO_A_BUF0LEN: next_rdata = buf0_len;
            `TCO_A_SEGCTL:  next_rdata = seg_ctl;
            `TCO_A_MTU:     next_rdata = {16'h0000, mtu};
            `TCO_A_FRMLEN:  next_rdata = {16'h0000, frame_len};
            `TCO_A_SUM:     next_rdata = {16'h0000, sum};
            default:        next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_read ? next_rdata : 32'h00000000;
        end
    end
endmodule // tco_host

/* File: test/tco_host_props.sv */
`timescale 1ns/1ps
`include "tco_regs.vh"
module tco_host_props (
    input wire        i_clock,
    input wire        i_reset,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_write,
    input wire        i_read,
    input wire [31:0] o_rdata,
    input wire        o_mem_write,
    input wire [31:0] o_mem_addr,
    input wire [31:0] o_mem_wdata,
    input wire [3:0]  o_mem_be,
    input wire        o_busy
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence s_sum; !o_mem_write [*7]; endsequence
    sequence s_blk; o_mem_write [*8]; endsequence
    wire seed = o_mem_write && o_mem_be != 4'hf;
    chk_block_order:
        assert property ($rose(o_busy) |-> s_sum ##1 s_blk) else $error("block write timing");
    chk_addr_step:
        assert property (o_mem_write && o_mem_be == 4'hf && $past(o_mem_write) && $past(o_mem_be) == 4'hf
            |-> o_mem_addr == $past(o_mem_addr) + 32'h4) else $error("block address step");
    chk_seed_pair:
        assert property (seed |-> o_mem_wdata[31:16] == o_mem_wdata[15:0]) else $error("seed halves differ");
    chk_seed_half:
        assert property (seed |-> o_mem_addr[1:0] == 2'b00 && (o_mem_be == 4'h3 || o_mem_be == 4'hc))
            else $error("seed lane");
    chk_write_busy:
        assert property (o_mem_write |-> o_busy) else $error("write while idle");
    chk_busy_cause:
        assert property ($rose(o_busy) |-> $past(i_write) && $past(i_addr) == `TCO_A_CTRL && $past(i_wdata[0]))
            else $error("busy without go");
    chk_busy_end:
        assert property ($fell(o_busy) |-> $past(o_mem_write)) else $error("busy end");
    chk_busy_len:
        assert property ($rose(o_busy) |-> o_busy [*8] ##1 o_busy [*6]) else $error("busy too short");
endmodule // tco_host_props

/* File: test/tco_mem_model.sv */
`timescale 1ns/1ps
module tco_mem_model (
    input wire        i_clock,
    input wire        i_write,
    input wire [31:0] i_addr,
    input wire [31:0] i_wdata,
    input wire [3:0]  i_be
);
    logic [31:0] mem [logic [31:0]];
    int          writes = 0;
    // unwritten words read as a marker pattern
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : 32'hdead_beef;
    endfunction
    // far side completes the sum seeded by the host
    function automatic logic [15:0] finish(input logic [15:0] seed, input logic udp);
        logic [15:0] c;
        c = ~seed;
        return (udp && c == 16'h0000) ? 16'hffff : c;
    endfunction
    always @(posedge i_clock) begin : store
        logic [31:0] key;
        logic [31:0] word;
        if (i_write) begin
            key = {i_addr[31:2], 2'b00};
            word = peek(key);
            for (int b = 0; b < 4; b++)
                if (i_be[b])
                    word[8*b +: 8] = i_wdata[8*b +: 8];
            mem[key] = word;
            writes++;
        end
    end
endmodule // tco_mem_model

/* File: test/tx_checksum_offload_tb.sv */
`timescale 1ns/1ps
`include "tco_regs.vh"
module tx_checksum_offload_tb;
    logic        i_clock;
    logic        i_reset;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_write;
    logic        i_read;
    wire  [31:0] o_rdata;
    wire         o_mem_write;
    wire  [31:0] o_mem_addr;
    wire  [31:0] o_mem_wdata;
    wire  [3:0]  o_mem_be;
    wire         o_busy;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [31:0] rv;
    logic [15:0] pw [6] = '{16'hffff, 16'h0001, 16'h1234, 16'h8000, 16'h8000, 16'h0002};
    tco_host u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_mem_be(o_mem_be), .o_busy(o_busy));
    tco_mem_model u_mem (.i_clock(i_clock), .i_write(o_mem_write), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .i_be(o_mem_be));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        @(negedge i_clock);
        d = o_rdata;
        @(posedge i_clock);
    endtask
    task automatic apply_reset();
        i_reset <= 1'b1;
        repeat (20) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic run_frame(input logic tcp, input logic ls);
        logic [31:0] mode;
        logic [31:0] seg;
        logic [31:0] ex [8];
        logic [31:0] wv [8];
        logic [31:0] sa;
        logic [31:0] d;
        logic [16:0] t;
        logic [15:0] s;
        int          n0;
        mode = {8'h00, ls, tcp, 2'b11, 20'h12345};
        seg = ls ? 32'h05b4_0040 : 32'h0210_0040;
        ex = '{32'ha000_0004, 32'h2000, 32'h3000, seg, {mode[31:20], 20'h0}, 32'h220e_0000, 32'h4000, 32'h0100_0200};
        wv = '{ex[0], ex[1], ex[2], mode, 32'h220e_0abc, ex[6], ex[7], seg};
        s = 16'h0;
        foreach (pw[i]) begin
            t = s + pw[i];
            s = t[15:0] + t[16];
        end
        sa = 32'h4022 + (tcp ? 32'h10 : 32'h6);
        apply_reset();
        wr(`TCO_A_BASE, 32'h1000);
        for (int i = 0; i < 8; i++)
            wr(`TCO_A_CMDWORD + 8'(4 * i), wv[i]);
        wr(`TCO_A_FRMLEN, 32'h64);
        foreach (pw[i])
            wr(`TCO_A_PHDR0 + 8'(4 * i), {16'h0, pw[i]});
        n0 = u_mem.writes;
        wr(`TCO_A_CTRL, 32'h1);
        wr(`TCO_A_BASE, 32'h9000);
        @(negedge i_clock);
        for (int k = 0; k < 40 && o_busy !== 1'b0; k++)
            @(negedge i_clock);
        @(posedge i_clock);
        rd(`TCO_A_SUM, d);
        check("sum", {16'h0, s}, d);
        rd(`TCO_A_STATUS, d);
        check("status", 32'h2, d);
        rd(`TCO_A_BASE, d);
        check("base", 32'h1000, d);
        foreach (ex[i])
            check("block word", ex[i], u_mem.peek(32'h1000 + 32'(4 * i)));
        d = u_mem.peek({sa[31:2], 2'b00});
        check("seed", {16'h0, s[7:0], s[15:8]}, {16'h0, sa[1] ? d[31:16] : d[15:0]});
        check("device sum", {16'h0, (!tcp && s == 16'hffff) ? 16'hffff : ~s},
            {16'h0, u_mem.finish(sa[1] ? {d[23:16], d[31:24]} : {d[7:0], d[15:8]}, !tcp)});
        check("writes", 32'd9, 32'(u_mem.writes - n0));
    endtask
    task automatic err_case(input logic [31:0] mode, input logic [31:0] ctrl, input logic [31:0] len,
        input logic [31:0] exp, input int nw);
        logic [31:0] d;
        int          n0;
        apply_reset();
        n0 = u_mem.writes;
        wr(`TCO_A_MODE, mode);
        wr(`TCO_A_FRMLEN, len);
        wr(`TCO_A_CTRL, ctrl);
        wr(`TCO_A_CTRL, ctrl | 32'h1);
        repeat (20) @(posedge i_clock);
        check("busy", 32'h0, {31'h0, o_busy});
        rd(`TCO_A_STATUS, d);
        check("status", exp, d);
        check("writes", 32'(nw), 32'(u_mem.writes - n0));
    endtask
    initial begin
        i_reset = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_write = 1'b0;
        i_read = 1'b0;
        @(posedge i_clock);
        apply_reset();
        rd(`TCO_A_MTU, rv);
        check("mtu", 32'h05ee, rv);
        rd(8'h38, rv);
        check("unmapped", 32'h0, rv);
        run_frame(1'b1, 1'b0);
        run_frame(1'b0, 1'b0);
        run_frame(1'b1, 1'b1);
        err_case(32'h0080_0000, 32'h0, 32'h64, 32'h4, 0);
        err_case(32'h0010_0000, 32'h2, 32'h64, 32'h8, 0);
        err_case(32'h0210_0000, 32'h0, 32'h5eb, 32'h10, 0);
        err_case(32'h0210_0000, 32'h0, 32'h5ea, 32'h2, 8);
        summarize();
    end
endmodule // tx_checksum_offload_tb
bind tco_host tco_host_props u_props (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_be(o_mem_be), .o_busy(o_busy));
